// File: aio_map.vh
// register map, field layout and timing constants of the accessory i/o block
`ifndef AIO_MAP_VH
`define AIO_MAP_VH
// register byte offsets
`define AIO_REG_CTRL 8'h00
`define AIO_REG_ACC 8'h04
`define AIO_REG_INSTAT 8'h08
`define AIO_REG_ANA12 8'h0C
`define AIO_REG_ANA34 8'h10
`define AIO_REG_ISTAT 8'h14
`define AIO_REG_IMASK 8'h18
`define AIO_REG_ROUTE 8'h1C
// control register fields
`define AIO_CTRL_MODE_LO 0
`define AIO_CTRL_MODE_HI 1
`define AIO_CTRL_LOOP_LO 2
`define AIO_CTRL_LOOP_HI 3
`define AIO_CTRL_SINGLE 4
`define AIO_CTRL_SOI_LO 5
`define AIO_CTRL_SOI_HI 6
`define AIO_CTRL_ENC 7
`define AIO_CTRL_ESHARE 8
`define AIO_CTRL_W 9
`define AIO_CTRL_RST 9'h000
// operating modes
`define AIO_MODE_SERIAL 2'h0
`define AIO_MODE_RADIO 2'h1
`define AIO_MODE_ANALOG 2'h2
// loop modes
`define AIO_LOOP_OPEN 2'h0
`define AIO_LOOP_POS 2'h1
`define AIO_LOOP_SPEED 2'h2
// stop/invert functions
`define AIO_SOI_NONE 2'h0
`define AIO_SOI_ESTOP 2'h1
`define AIO_SOI_INVERT 2'h2
// status field codes
`define AIO_FLD_OFF 8'h00
`define AIO_FLD_ON 8'h01
// interrupt bits
`define AIO_IRQ_E 0
`define AIO_IRQ_F 1
`define AIO_IRQ_SOI 2
`define AIO_IRQ_ACC 3
`define AIO_IRQ_W 4
// adc levels: 0.5V of 5V full scale, mid-scale bias
`define AIO_E_THRESH 8'h1A
`define AIO_ADC_MID 8'h80
// radio pulse timing
// cycles of the 50 MHz clock in one microsecond
`define AIO_US_CYC 6'h32
// on at 1750 us or more, off at 1250 us or less, cap 4095 us
`define AIO_RC_ON_US 12'h6D6
`define AIO_RC_OFF_US 12'h4E2
`define AIO_RC_MAX_US 12'hFFF
`endif

// File: aio_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module aio_sync #(
  parameter W = 3,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // raw and filtered levels
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1;
      reg s2;
      reg s3;
      reg q;
      // s1 feeds only s2; q moves once s2 and s3 agree
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1 <= RST_VAL[g];
          s2 <= RST_VAL[g];
          s3 <= RST_VAL[g];
          q <= RST_VAL[g];
        end else begin
          s1 <= d_i[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign q_o[g] = q;
    end
  endgenerate
endmodule // aio_sync

// File: aio_top.v
// accessory output, digital input status and analog input routing
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "aio_map.vh"
module aio_top (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // digital pins
  input wire in_e_i,
  input wire in_f_i,
  input wire stop_or_invert_input_n_i,
  // accessory open-drain output
  output wire acc_o,
  output wire acc_oe_o,
  // adc samples, 0 at 0V, 255 at 5V
  input wire [7:0] ana1_i,
  input wire [7:0] ana2_i,
  input wire [7:0] ana3_i,
  input wire [7:0] ana4_i,
  // routed analog roles, signed
  output reg [7:0] cmd1_o,
  output reg [7:0] cmd2_o,
  output reg [7:0] fb1_o,
  output reg [7:0] fb2_o,
  output reg cmd_valid_o,
  output reg fb1_valid_o,
  output reg fb2_valid_o,
  // motor control steering
  output reg estop_o,
  output reg invert_o,
  output reg radio_ch2_o,
  output reg radio_ch3_o,
  // interrupt
  output wire irq_o
);
  // ascii hex digit of a nibble
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      if (n < 4'hA) begin
        hex_chr = 8'h30 + {4'h0, n};
      end else begin
        hex_chr = 8'h37 + {4'h0, n};
      end
    end
  endfunction

  localparam [11:0] RC_ON = `AIO_RC_ON_US;
  localparam [11:0] RC_OFF = `AIO_RC_OFF_US;
  localparam [11:0] RC_MAX = `AIO_RC_MAX_US;
  localparam [5:0] US_CYC = `AIO_US_CYC;

  reg [`AIO_CTRL_W-1:0] ctrl;
  reg acc_cmd;
  reg acc_rc;
  reg acc_on;
  reg [`AIO_IRQ_W-1:0] istat;
  reg [`AIO_IRQ_W-1:0] imask;
  reg [`AIO_IRQ_W-1:0] next_istat;
  reg [2:0] pin_q;
  reg [5:0] us_div;
  reg us_tick;
  reg [11:0] rc_width;
  reg [7:0] fld_e;
  reg [7:0] fld_f;
  reg [7:0] fld_soi;
  reg [31:0] next_rdata;
  wire [2:0] pin_s;
  wire [1:0] mode;
  wire [1:0] loop_mode;
  wire [1:0] soi_fn;
  wire single_ch;
  wire enc_fitted;
  wire e_shared;
  wire e_level;
  wire e_avail;
  wire f_avail;
  wire soi_low;
  wire [7:0] s1;
  wire [7:0] s2;
  wire [7:0] s3;
  wire [7:0] s4;
  wire [3:0] evt;
  wire wr_istat;
  wire wr_acc;
  reg acc_oe_q;

  assign mode = ctrl[`AIO_CTRL_MODE_HI:`AIO_CTRL_MODE_LO];
  assign loop_mode = ctrl[`AIO_CTRL_LOOP_HI:`AIO_CTRL_LOOP_LO];
  assign soi_fn = ctrl[`AIO_CTRL_SOI_HI:`AIO_CTRL_SOI_LO];
  assign single_ch = ctrl[`AIO_CTRL_SINGLE];
  assign enc_fitted = ctrl[`AIO_CTRL_ENC];
  assign e_shared = ctrl[`AIO_CTRL_ESHARE];
  assign wr_istat = wr_i && (addr_i == `AIO_REG_ISTAT);
  assign wr_acc = wr_i && (addr_i == `AIO_REG_ACC);

  // pins reset high, the pulled-up idle level of E and stop
  aio_sync #(
    .W(3),
    .RST_VAL(3'h7)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i({stop_or_invert_input_n_i, in_f_i, in_e_i}),
    .q_o(pin_s)
  );

  // input availability follows mode and encoder fitting
  assign e_avail = !enc_fitted && (mode != `AIO_MODE_RADIO);
  assign f_avail = (mode != `AIO_MODE_RADIO);
  // an open pin reads high through the pull-up, so On
  assign e_level = e_shared ? (ana4_i > `AIO_E_THRESH)
                            : pin_s[0];
  assign soi_low = !pin_s[2];

  // adc to signed: mid-scale 2.5V becomes zero
  assign s1 = ana1_i ^ `AIO_ADC_MID;
  assign s2 = ana2_i ^ `AIO_ADC_MID;
  assign s3 = ana3_i ^ `AIO_ADC_MID;
  assign s4 = ana4_i ^ `AIO_ADC_MID;

  // control and interrupt mask registers
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `AIO_CTRL_RST;
      imask <= {`AIO_IRQ_W{1'b0}};
    end else if (wr_i) begin
      if (addr_i == `AIO_REG_CTRL) begin
        ctrl <= wdata_i[`AIO_CTRL_W-1:0];
      end
      if (addr_i == `AIO_REG_IMASK) begin
        imask <= wdata_i[`AIO_IRQ_W-1:0];
      end
    end
  end

  // serial accessory command: bit 0 one is on, zero is off
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_cmd <= 1'b0;
    end else if (wr_acc) begin
      acc_cmd <= wdata_i[0];
    end
  end

  // microsecond enable for radio pulse timing
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      us_div <= 6'h00;
      us_tick <= 1'b0;
    end else if (us_div == US_CYC - 6'h01) begin
      us_div <= 6'h00;
      us_tick <= 1'b1;
    end else begin
      us_div <= us_div + 6'h01;
      us_tick <= 1'b0;
    end
  end

  // third radio channel pulse width; hysteresis keeps
  // a stick near centre from chattering the load
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_width <= 12'h000;
      acc_rc <= 1'b0;
    end else if (mode != `AIO_MODE_RADIO || enc_fitted) begin
      rc_width <= 12'h000;
      acc_rc <= 1'b0;
    end else if (pin_s[0]) begin
      if (us_tick && rc_width != RC_MAX) begin
        rc_width <= rc_width + 12'h001;
      end
    end else begin
      if (pin_q[0]) begin
        if (rc_width >= RC_ON) begin
          acc_rc <= 1'b1;
        end else if (rc_width <= RC_OFF) begin
          acc_rc <= 1'b0;
        end
      end
      rc_width <= 12'h000;
    end
  end

  // accessory drive: source picked by mode
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_on <= 1'b0;
    end else if (mode == `AIO_MODE_RADIO) begin
      acc_on <= acc_rc;
    end else begin
      acc_on <= acc_cmd;
    end
  end
  // open drain: sinks the load while on, floats otherwise
  assign acc_o = 1'b0;
  assign acc_oe_o = acc_on;

  // status reply fields, 00 off and 01 on
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fld_e <= `AIO_FLD_OFF;
      fld_f <= `AIO_FLD_OFF;
      fld_soi <= `AIO_FLD_ON;
    end else begin
      fld_e <= (e_avail && e_level) ? `AIO_FLD_ON
                                    : `AIO_FLD_OFF;
      fld_f <= (f_avail && pin_s[1]) ? `AIO_FLD_ON
                                     : `AIO_FLD_OFF;
      fld_soi <= pin_s[2] ? `AIO_FLD_ON : `AIO_FLD_OFF;
    end
  end

  // stop/invert function and radio channel lines
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      estop_o <= 1'b0;
      invert_o <= 1'b0;
      radio_ch2_o <= 1'b0;
      radio_ch3_o <= 1'b0;
    end else begin
      // none and general purpose leave the motors alone
      estop_o <= (soi_fn == `AIO_SOI_ESTOP) && soi_low;
      invert_o <= (soi_fn == `AIO_SOI_INVERT) && soi_low;
      radio_ch2_o <= (mode == `AIO_MODE_RADIO) && pin_s[1];
      radio_ch3_o <= (mode == `AIO_MODE_RADIO) && !enc_fitted
                     && pin_s[0];
    end
  end

  // analog role routing by operating and loop mode
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd1_o <= 8'h00;
      cmd2_o <= 8'h00;
      fb1_o <= 8'h00;
      fb2_o <= 8'h00;
      cmd_valid_o <= 1'b0;
      fb1_valid_o <= 1'b0;
      fb2_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= (mode == `AIO_MODE_ANALOG);
      cmd1_o <= s1;
      cmd2_o <= s2;
      if (loop_mode == `AIO_LOOP_OPEN) begin
        fb1_valid_o <= 1'b0;
        fb2_valid_o <= 1'b0;
        fb1_o <= 8'h00;
        fb2_o <= 8'h00;
      end else if (mode == `AIO_MODE_ANALOG) begin
        fb1_valid_o <= 1'b1;
        fb2_valid_o <= 1'b1;
        fb1_o <= s3;
        fb2_o <= s4;
      end else begin
        fb1_valid_o <= 1'b1;
        fb2_valid_o <= !single_ch;
        fb1_o <= s1;
        fb2_o <= single_ch ? 8'h00 : s2;
      end
    end
  end

  // input change and accessory change events
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q <= 3'h7;
    end else begin
      pin_q <= pin_s;
    end
  end
  assign evt[`AIO_IRQ_E] = e_avail && (pin_s[0] != pin_q[0]);
  assign evt[`AIO_IRQ_F] = f_avail && (pin_s[1] != pin_q[1]);
  assign evt[`AIO_IRQ_SOI] = pin_s[2] != pin_q[2];
  assign evt[`AIO_IRQ_ACC] = acc_on != acc_oe_q;

  // last accessory state, for its change event
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_oe_q <= 1'b0;
    end else begin
      acc_oe_q <= acc_on;
    end
  end

  // sticky status, write one to clear; a new event wins
  always @* begin
    next_istat = istat;
    if (wr_istat) begin
      next_istat = istat & ~wdata_i[`AIO_IRQ_W-1:0];
    end
    next_istat = next_istat | evt;
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      istat <= {`AIO_IRQ_W{1'b0}};
    end else begin
      istat <= next_istat;
    end
  end
  assign irq_o = |(istat & imask);

  // read mux; unmapped addresses read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (addr_i)
      `AIO_REG_CTRL: begin
        next_rdata[`AIO_CTRL_W-1:0] = ctrl;
      end
      `AIO_REG_ACC: begin
        next_rdata[0] = acc_cmd;
        next_rdata[1] = acc_on;
      end
      `AIO_REG_INSTAT: begin
        next_rdata = {8'h00, fld_e, fld_f, fld_soi};
      end
      `AIO_REG_ANA12: begin
        next_rdata = {hex_chr(s1[7:4]), hex_chr(s1[3:0]),
                      hex_chr(s2[7:4]), hex_chr(s2[3:0])};
      end
      `AIO_REG_ANA34: begin
        next_rdata = {hex_chr(s3[7:4]), hex_chr(s3[3:0]),
                      hex_chr(s4[7:4]), hex_chr(s4[3:0])};
      end
      `AIO_REG_ISTAT: begin
        next_rdata[`AIO_IRQ_W-1:0] = istat;
      end
      `AIO_REG_IMASK: begin
        next_rdata[`AIO_IRQ_W-1:0] = imask;
      end
      `AIO_REG_ROUTE: begin
        next_rdata = {fb1_o, fb2_o, 5'h00, cmd_valid_o,
                      fb1_valid_o, fb2_valid_o, 8'h00};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data valid the cycle after the strobe only
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule // aio_top

// File: aio_top_checker.sv
// port-level assertions for the accessory i/o block
`timescale 1ns/10ps
module aio_top_checker (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // pins and steering
  input wire logic stop_or_invert_input_n_i,
  input wire logic acc_o,
  input wire logic acc_oe_o,
  input wire logic cmd_valid_o,
  input wire logic estop_o,
  input wire logic invert_o,
  input wire logic radio_ch2_o,
  input wire logic radio_ch3_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] stb;
  logic prev;
  // cycles the stop pin held still; 7 outlasts the sync latency
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stb <= 3'h0;
      prev <= 1'b1;
    end else begin
      prev <= stop_or_invert_input_n_i;
      if (stop_or_invert_input_n_i != prev) stb <= 3'h0;
      else if (stb != 3'h7) stb <= stb + 3'h1;
    end
  end
  function automatic logic hexch(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction
  sequence s_rd(logic [7:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence s_acc_wr;
    cmd_valid_o && wr_i && addr_i == 8'h04;
  endsequence
  a_acc_drain: assert property (acc_o == 1'b0)
    else $error("accessory pin driven high");
  a_acc_follow: assert property (
    s_acc_wr |-> ##2 acc_oe_o == $past(wdata_i[0], 2))
    else $error("accessory does not follow command");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_stop_inv_excl: assert property (!(estop_o && invert_o))
    else $error("stop and invert both active");
  a_radio_excl: assert property (
    cmd_valid_o |-> !radio_ch2_o && !radio_ch3_o)
    else $error("radio channel out of radio mode");
  a_idle_no_action: assert property (
    stb == 3'h7 && stop_or_invert_input_n_i |-> !estop_o && !invert_o)
    else $error("open stop pin acts");
  a_instat_codes: assert property (s_rd(8'h08) |=>
    rdata_o[31:17] == 15'h0 && rdata_o[15:9] == 7'h0 && rdata_o[7:1] == 7'h0)
    else $error("status field not 00 or 01");
  a_stop_field: assert property (s_rd(8'h08) ##0 stb == 3'h7 |=>
    rdata_o[0] == $past(stop_or_invert_input_n_i))
    else $error("stop field wrong");
  a_ana_hex: assert property (s_rd(8'h0C) |=>
    hexch(rdata_o[31:24]) && hexch(rdata_o[7:0]))
    else $error("analog reply not hex text");
endmodule // aio_top_checker

// File: aio_pins_model.sv
// external switches, pulled-up pins and radio pulse source
`timescale 1ns/10ps
`include "aio_map.vh"
module aio_pins_model (
  // clock
  input wire logic sys_clk_i,
  // switch contacts, high = closed
  input wire logic e_sw_i,
  input wire logic f_sw_i,
  input wire logic stop_sw_i,
  // pin levels seen by the block
  output wire logic in_e_o,
  output wire logic in_f_o,
  output wire logic stop_n_o
);
  logic rc_on = 1'b0;
  logic rc_lvl = 1'b0;
  // pull-up reads high while open; receiver drives it in radio use
  assign in_e_o = e_sw_i ? 1'b0 : (rc_on ? rc_lvl : 1'b1);
  // switch to supply with a pull-down, so never floating
  assign in_f_o = f_sw_i;
  // closing the switch grounds the pin
  assign stop_n_o = !stop_sw_i;
  // one receiver pulse of given high width, line low after
  task automatic rc_pulse(input int us);
    @(posedge sys_clk_i);
    rc_on <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    rc_lvl <= 1'b1;
    repeat (us * `AIO_US_CYC) @(posedge sys_clk_i);
    rc_lvl <= 1'b0;
  endtask
endmodule // aio_pins_model

// File: test_accessory_io_and_sensor_routing.sv
// self-checking bench for the accessory i/o block
`timescale 1ns/10ps
`include "aio_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_accessory_io_and_sensor_routing;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] a1 = 8'h80;
  logic [7:0] a2 = 8'h80;
  logic [7:0] a3 = 8'h80;
  logic [7:0] a4 = 8'h80;
  logic e_sw = 1'b0;
  logic f_sw = 1'b0;
  logic s_sw = 1'b0;
  wire in_e, in_f, s_n, acc_oe_o, irq_o, estop_o, invert_o, radio_ch2_o;
  wire radio_ch3_o;
  wire [7:0] cmd1_o, cmd2_o;
  wire [31:0] rdata_o;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [79:0] r;
  // ctrl, ana1..4, expected route word
  logic [79:0] rows [0:5] = '{80'h0006_80_00_FF_10_7F900700,
    80'h000A_00_FF_80_81_00010700, 80'h0008_00_FF_80_80_807F0300,
    80'h0018_80_55_80_80_00000200, 80'h0005_12_34_80_80_92B40300,
    80'h0000_12_34_56_78_00000000};
  aio_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .in_e_i(in_e), .in_f_i(in_f), .stop_or_invert_input_n_i(s_n),
    .acc_o(), .acc_oe_o(acc_oe_o), .ana1_i(a1), .ana2_i(a2), .ana3_i(a3),
    .ana4_i(a4), .cmd1_o(cmd1_o), .cmd2_o(cmd2_o), .fb1_o(), .fb2_o(),
    .cmd_valid_o(), .fb1_valid_o(), .fb2_valid_o(), .estop_o(estop_o),
    .invert_o(invert_o), .radio_ch2_o(radio_ch2_o),
    .radio_ch3_o(radio_ch3_o), .irq_o(irq_o));
  aio_pins_model pins (.sys_clk_i(sys_clk_i), .e_sw_i(e_sw), .f_sw_i(f_sw),
    .stop_sw_i(s_sw), .in_e_o(in_e), .in_f_o(in_f), .stop_n_o(s_n));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  function automatic [7:0] nib(input [3:0] n);
    nib = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  function automatic [15:0] hx(input [7:0] b);
    hx = {nib(b[7:4] ^ 4'h8), nib(b[3:0])};
  endfunction
  task wr(input [7:0] a, input [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stands one cycle only, so sample just after its edge
  task chkr(input [7:0] a, input [31:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask
  // pins pass a multi-flop synchroniser before they show
  task settle;
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask
  task finish_test;
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, radio pulse alone takes about 88k cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chkr(`AIO_REG_CTRL, 32'h0);
    chkr(`AIO_REG_IMASK, 32'h0);
    settle;
    chkr(`AIO_REG_INSTAT, 32'h00010001);
    `CHK(acc_oe_o, 1'b0)
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      @(posedge sys_clk_i);
      {a1, a2, a3, a4} <= r[63:32];
      wr(`AIO_REG_CTRL, {16'h0, r[79:64]});
      repeat (3) @(posedge sys_clk_i);
      chkr(`AIO_REG_ROUTE, r[31:0]);
      `CHK({cmd1_o, cmd2_o}, {r[63:56] - 8'h80, r[55:48] - 8'h80})
      chkr(`AIO_REG_ANA12, {hx(r[63:56]), hx(r[55:48])});
      chkr(`AIO_REG_ANA34, {hx(r[47:40]), hx(r[39:32])});
    end
    wr(`AIO_REG_CTRL, 32'h0);
    {e_sw, f_sw, s_sw} <= 3'b111;
    settle;
    chkr(`AIO_REG_INSTAT, 32'h00000100);
    `CHK({estop_o, invert_o}, 2'b00)
    wr(`AIO_REG_CTRL, 32'h20);
    settle;
    `CHK({estop_o, invert_o}, 2'b10)
    wr(`AIO_REG_CTRL, 32'h40);
    settle;
    `CHK({estop_o, invert_o}, 2'b01)
    wr(`AIO_REG_CTRL, 32'h60);
    settle;
    `CHK({estop_o, invert_o}, 2'b00)
    wr(`AIO_REG_CTRL, 32'h40);
    {e_sw, s_sw} <= 2'b00;
    settle;
    `CHK(invert_o, 1'b0)
    chkr(`AIO_REG_INSTAT, 32'h00010101);
    wr(`AIO_REG_CTRL, 32'h80);
    settle;
    chkr(`AIO_REG_INSTAT, 32'h00000101);
    wr(`AIO_REG_CTRL, 32'h100);
    a4 <= 8'h1A;
    settle;
    chkr(`AIO_REG_INSTAT, 32'h00000101);
    @(posedge sys_clk_i);
    a4 <= 8'h1B;
    settle;
    chkr(`AIO_REG_INSTAT, 32'h00010101);
    wr(`AIO_REG_CTRL, 32'h0);
    wr(`AIO_REG_ISTAT, 32'h1F);
    wr(`AIO_REG_IMASK, 32'h08);
    wr(`AIO_REG_ACC, 32'h1);
    settle;
    `CHK({acc_oe_o, irq_o}, 2'b11)
    chkr(`AIO_REG_ACC, 32'h3);
    wr(`AIO_REG_IMASK, 32'h0);
    settle;
    `CHK(irq_o, 1'b0)
    wr(`AIO_REG_ISTAT, 32'h08);
    chkr(`AIO_REG_ISTAT, 32'h0);
    // mid-run reset drops the load and the command
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 `CHK({acc_oe_o, irq_o, estop_o, invert_o}, 4'h0)
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chkr(`AIO_REG_ACC, 32'h0);
    wr(`AIO_REG_CTRL, 32'h2);
    wr(`AIO_REG_ACC, 32'h1);
    settle;
    `CHK(acc_oe_o, 1'b1)
    wr(`AIO_REG_ACC, 32'h0);
    settle;
    `CHK(acc_oe_o, 1'b0)
    wr(8'h20, 32'hFF);
    chkr(8'h20, 32'h0);
    wr(`AIO_REG_CTRL, 32'h1);
    settle;
    `CHK(radio_ch2_o, 1'b1)
    `CHK(radio_ch3_o, 1'b1)
    chkr(`AIO_REG_INSTAT, 32'h00000001);
    pins.rc_pulse(1760);
    settle;
    `CHK(acc_oe_o, 1'b1)
    finish_test;
  end
endmodule // test_accessory_io_and_sensor_routing
bind aio_top aio_top_checker chk (.sys_clk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .stop_or_invert_input_n_i, .acc_o, .acc_oe_o,
  .cmd_valid_o, .estop_o, .invert_o, .radio_ch2_o, .radio_ch3_o);
